// >>> logic/fbs_sram_port.sv
// Contract
// - Clock registers all inputs except output enable, sleep and burst order select.
// - New address loads only with all selects active and a strobe asserted.
// - Data pins drive only when selected, reading, and output enable low.
// - Master select inactive blocks the processor strobe.
// - Second select active high, third active low, sampled on qualifying strobes.
// - Processor strobe low loads an address or enters standby when unselected.
// - Controller strobe low loads an address or enters standby when unselected.
// - Advance low without a load steps the burst to the next address.
// - Global write low writes all 18 bits regardless of byte inputs.
// - Byte writes count only with byte gate low; gate high means read.
// - Each low byte enable writes its byte; none low means read.
// - Output drivers follow output enable without waiting for a clock.
// - Burst order select high or open gives interleaved, low gives linear.
// - Interleaved beat low bits are start bits XOR beat index.
// - Linear beat low bits are start plus beat index modulo four.
// - Sleep deselects, ignores inputs, floats outputs, keeps the stored data.
// - Sleep lasts while the sleep input stays high, starting and ending two edges late through its synchroniser.
// - Sleep input open reads as low and the part runs normally.
// - Advance ignored on processor strobe edge; later steps need controller strobe high and processor strobe high or blocked.
// - Processor strobe always starts a read; byte writes sampled on later edges.
// - Controller start needs processor strobe high; write inputs sampled same edge.
// - Byte write sampled low turns drivers off and captures input data.
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.svh"

module fbs_sram_port
  import fbs_pkg::*;
#(
  parameter int ADDR_W = `FBS_ADDR_W,
  parameter int DATA_W = `FBS_DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Synchronous bus from the controller
  input wire fbs_bus_s bus,
  input wire logic [ADDR_W-1:0] addr,
  // Data pins split into three signals
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe,
  // Asynchronous and static pins
  input wire logic out_enable_n,
  input wire logic sleep_req,
  input wire logic burst_order_sel_n,
  // Status
  output logic asleep
);

  localparam int BW = `FBS_BURST_W;

  // ----------------------------------------------------------------
  // Burst order helper
  // ----------------------------------------------------------------

  // Low address bits of one beat
  // Interleave flips bits and linear adds; both wrap inside two bits
  function automatic logic [BW-1:0] burst_low(input logic [BW-1:0] start,
                                               input logic [BW-1:0] beat,
                                               input logic interleaved);
    logic [BW-1:0] res;
    res = interleaved ? (start ^ beat) : (start + beat);
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers for the sleep and burst order inputs
  // ----------------------------------------------------------------

  logic [1:0] sleep_sync;
  logic [1:0] order_sync;
  logic sleep_s;
  logic order_s;

  // Two stages each; only the second stage feeds logic
  // The order pin is static in use, so its two-edge lag costs nothing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sleep_sync <= `FBS_SYNC_ZERO;
      order_sync <= `FBS_SYNC_ZERO;
    end else begin
      sleep_sync <= {sleep_sync[0], sleep_req};
      order_sync <= {order_sync[0], burst_order_sel_n};
    end
  end

  assign sleep_s = sleep_sync[1];
  assign order_s = order_sync[1];

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------

  fbs_state_e state;
  fbs_state_e next_state;
  logic [ADDR_W-1:0] base;
  logic [ADDR_W-1:0] next_base;
  logic [BW-1:0] beat;
  logic [BW-1:0] next_beat;

  wire sel_ok;
  wire strobe_p;
  wire strobe_c;
  wire strobe_any;
  wire load;
  wire standby;
  wire active;
  wire cont;
  wire step;
  wire write_req;
  wire [1:0] lane_req;
  wire [1:0] lane_we;
  wire mem_write;
  wire [ADDR_W-1:0] burst_addr;
  wire [ADDR_W-1:0] mem_addr;

  // All three selects active
  assign sel_ok = ~bus.master_select_n & bus.select_hi & ~bus.select_lo_n;
  // Processor strobe only counts with master select active
  assign strobe_p = ~bus.proc_addr_strobe_n & ~bus.master_select_n;
  // Controller strobe needs the processor strobe high or blocked
  assign strobe_c = ~bus.ctrl_addr_strobe_n & ~strobe_p;
  assign strobe_any = strobe_p | strobe_c;
  assign load = strobe_any & sel_ok & ~sleep_s;
  assign standby = strobe_any & ~sel_ok;
  assign active = (state == FBS_READ) | (state == FBS_WRITE);
  // Continue only when no strobe is taken
  assign cont = ~strobe_any & active & ~sleep_s;
  assign step = cont & ~bus.burst_advance_n;

  // Lane requests from the write pins
  assign lane_req = ~bus.global_write_n ? 2'h3 :
                    bus.byte_write_gate_n ? 2'h0 :
                    {~bus.byte_high_write_n, ~bus.byte_low_write_n};
  assign write_req = |lane_req;

  // Write only from a controller start or a continued cycle
  // A processor start never writes; its write pins are left unread
  assign lane_we = ((load & strobe_c) | cont) ? lane_req : 2'h0;
  assign mem_write = |lane_we;

  // ----------------------------------------------------------------
  // Next state and burst address
  // ----------------------------------------------------------------

  // Sleep beats every strobe; controller start picks read or write
  always_comb begin
    next_state = state;
    next_base = base;
    next_beat = beat;
    if (sleep_s) begin
      next_state = FBS_SNOOZE;
    end else if (load) begin
      next_base = addr;
      next_beat = `FBS_BEAT_ZERO;
      next_state = (strobe_c & write_req) ? FBS_WRITE : FBS_READ;
    end else if (standby) begin
      next_state = FBS_DESEL;
    end else if (state == FBS_SNOOZE) begin
      next_state = FBS_DESEL;
    end else if (cont) begin
      next_state = write_req ? FBS_WRITE : FBS_READ;
      if (step) begin
        next_beat = beat + `FBS_BEAT_ONE;
      end
    end
  end

  // Upper bits fixed; only the two low bits walk
  assign burst_addr = {base[ADDR_W-1:BW], burst_low(base[BW-1:0], next_beat, order_s)};
  // A load reads straight from the pins so the first word is not a cycle late
  assign mem_addr = load ? addr : burst_addr;

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------

  // Every synchronous pin is taken on this edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= FBS_DESEL;
      base <= '0;
      beat <= `FBS_BEAT_ZERO;
    end else begin
      state <= next_state;
      base <= next_base;
      beat <= next_beat;
    end
  end

  // Sleep indication follows the synchronised pin
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      asleep <= 1'b0;
    end else begin
      asleep <= sleep_s;
    end
  end

  // ----------------------------------------------------------------
  // Array and data pins
  // ----------------------------------------------------------------

  // Input data captured into the array on the write edge
  fbs_store #(
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W),
    .LANES(2)
  ) u_store (
    .clk(clk),
    .addr(mem_addr),
    .lane_we(lane_we),
    .wdata(dq_in),
    .rdata(dq_out)
  );

  // Drivers follow the raw enable and sleep pins with no clock; this is
  // the one output not taken from a flop, since waiting would break timing
  assign dq_oe = (state == FBS_READ) & ~out_enable_n & ~sleep_req;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Load, select and burst checks

  a_load_addr: assert property (load |=> base == $past(addr))
    else $error("address not loaded on a qualified strobe");

  a_desel_standby: assert property (standby & ~sleep_s |=> state == FBS_DESEL)
    else $error("unselected strobe did not deselect");

  a_proc_blocked: assert property (
    active & bus.master_select_n & bus.ctrl_addr_strobe_n & ~sleep_s |=> state != FBS_DESEL)
    else $error("blocked processor strobe ended the burst");

  a_proc_reads: assert property (strobe_p & sel_ok & ~sleep_s |=> state == FBS_READ)
    else $error("processor start did not begin a read");

  a_ctrl_write: assert property (
    strobe_c & sel_ok & ~sleep_s & ~bus.global_write_n |=> state == FBS_WRITE)
    else $error("controller write start not taken");

  a_beat_step: assert property (step |=> beat == $past(beat) + 2'h1)
    else $error("burst did not advance");

  a_beat_hold: assert property (cont & bus.burst_advance_n |=> $stable(beat))
    else $error("burst moved without advance");

  a_upper_fixed: assert property (active & ~load |=> $stable(base))
    else $error("upper address changed inside a burst");

  a_interleave: assert property (
    load & order_s & ~sleep_s ##1 step [*3] |-> burst_addr[1:0] == (base[1:0] ^ 2'h3))
    else $error("interleaved order wrong");

  a_linear: assert property (
    load & ~order_s & ~sleep_s ##1 step [*3] |-> burst_addr[1:0] == 2'(base[1:0] + 2'h3))
    else $error("linear order wrong");

  a_write_float: assert property (state == FBS_WRITE |-> !dq_oe)
    else $error("drivers on during write");

  a_sleep_float: assert property (sleep_req |-> !dq_oe)
    else $error("drivers on while asleep");

  a_sleep_hold: assert property (sleep_s & ~sys_rst |=> state == FBS_SNOOZE [*1])
    else $error("sleep did not deselect");

  // ----------------------------------------------------------------
  // Write lanes, wake-up and drivers
  // ----------------------------------------------------------------

  // Lanes are judged from the pins, so a slip in the decode shows here
  a_global_all: assert property (
    load & strobe_c & ~bus.global_write_n |-> lane_we == 2'h3)
    else $error("global write missed a lane");

  a_gate_read: assert property (
    bus.global_write_n & bus.byte_write_gate_n |-> lane_we == 2'h0)
    else $error("byte gate high still wrote");

  a_no_lane: assert property (
    bus.global_write_n & bus.byte_high_write_n & bus.byte_low_write_n |-> lane_we == 2'h0)
    else $error("write with no byte enable");

  a_low_lane: assert property (
    strobe_c & sel_ok & ~sleep_s & bus.global_write_n & ~bus.byte_write_gate_n
    & ~bus.byte_low_write_n & bus.byte_high_write_n |-> lane_we == 2'h1)
    else $error("low byte enable not honoured");

  // A processor start is always a read, whatever the write pins say
  a_proc_no_write: assert property (strobe_p |-> lane_we == 2'h0)
    else $error("processor start wrote the array");

  a_proc_beat: assert property (strobe_p & sel_ok & ~sleep_s |=> beat == 2'h0)
    else $error("advance taken on the processor start edge");

  // The array must keep its words through sleep, so no lane may fire
  a_sleep_no_write: assert property (sleep_s |-> lane_we == 2'h0)
    else $error("array written while asleep");

  a_sleep_wake: assert property (
    state == FBS_SNOOZE & ~sleep_s |=> state != FBS_SNOOZE)
    else $error("sleep outlasted its input");

  a_desel_float: assert property (state == FBS_DESEL |-> !dq_oe)
    else $error("drivers on while deselected");

  // Output enable acts without a clock, so this holds at every edge
  a_read_drive: assert property (
    state == FBS_READ & ~out_enable_n & ~sleep_req |-> dq_oe)
    else $error("drivers off during an enabled read");

  // ----------------------------------------------------------------
  // Scenario covers
  // ----------------------------------------------------------------

  // Each main kind of transfer must be seen at least once
  c_read_burst: cover property (strobe_p & sel_ok ##1 step [*3]);
  c_byte_write: cover property (strobe_c & sel_ok & bus.global_write_n & lane_req == 2'h1);
  c_sleep_exit: cover property (state == FBS_SNOOZE ##1 state == FBS_DESEL);
  c_linear_wrap: cover property (~order_s & step & beat == 2'h3);
  c_msel_hold: cover property (active & bus.master_select_n & ~bus.proc_addr_strobe_n);

endmodule

`default_nettype wire

// >>> logic/fbs_defs.svh
`ifndef FBS_DEFS_SVH
`define FBS_DEFS_SVH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define FBS_ADDR_W 20
`define FBS_DATA_W 18
`define FBS_LANES 2

// ----------------------------------------------------------------
// Burst counter field
// ----------------------------------------------------------------
`define FBS_BURST_W 2
`define FBS_BEAT_ZERO 2'h0
`define FBS_BEAT_ONE 2'h1
`define FBS_SYNC_ZERO 2'h0

`endif

// >>> logic/fbs_pkg.sv
package fbs_pkg;

  // Synchronous control pins, all active levels as on the pins
  typedef struct packed {
    logic master_select_n;
    logic select_hi;
    logic select_lo_n;
    logic proc_addr_strobe_n;
    logic ctrl_addr_strobe_n;
    logic burst_advance_n;
    logic global_write_n;
    logic byte_write_gate_n;
    logic byte_high_write_n;
    logic byte_low_write_n;
  } fbs_bus_s;

  // Cycle state of the array port
  typedef enum logic [1:0] {
    FBS_DESEL,
    FBS_READ,
    FBS_WRITE,
    FBS_SNOOZE
  } fbs_state_e;

endpackage

// >>> logic/fbs_store.sv
`timescale 1ns/1ps
`default_nettype none
`include "fbs_defs.svh"

// Byte-writable array; read data leaves through a register
module fbs_store #(
  parameter int ADDR_W = `FBS_ADDR_W,
  parameter int DATA_W = `FBS_DATA_W,
  parameter int LANES = `FBS_LANES
) (
  // Clock
  input wire logic clk,
  // Access
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES-1:0] lane_we,
  input wire logic [DATA_W-1:0] wdata,
  output logic [DATA_W-1:0] rdata
);

  localparam int LANE_W = DATA_W / LANES;

  logic [DATA_W-1:0] cells [0:(1 << ADDR_W)-1];

  // Per-lane write; a read of the written word returns the old value
  always_ff @(posedge clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (lane_we[i]) begin
        cells[addr][i*LANE_W +: LANE_W] <= wdata[i*LANE_W +: LANE_W];
      end
    end
    rdata <= cells[addr];
  end

endmodule

`default_nettype wire

// >>> tb/fbs_ctl_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Bus master on the far side of the port
// ----------------------------------------
module fbs_ctl_model
  import fbs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Data pins as seen from the master
  input wire logic [17:0] dq_out,
  input wire logic dq_oe,
  output logic [17:0] dq_line,
  // Bus and side pins
  output var fbs_bus_s bus,
  output logic [19:0] addr,
  output logic out_enable_n,
  output logic sleep_req,
  output logic burst_order_sel_n
);
  // Idle cycles, all selects active and no strobe, given while the part wakes
  localparam int RECOV = 2;
  logic [17:0] drv;
  logic wr;

  // Released line toggles, so a stale copy never passes for data
  assign dq_line = dq_oe ? dq_out : drv;

  initial begin
    bus = fbs_bus_s'(10'h17F);
    addr = 20'h00000;
    drv = 18'h00000;
    wr = 1'b0;
    out_enable_n = 1'b1;
    sleep_req = 1'b0;
    burst_order_sel_n = 1'b1;
  end

  // One edge: enter just after a rising edge, leave just after the next
  task automatic cyc(input logic [9:0] b, input logic [19:0] a, input logic [17:0] d);
    logic [9:0] v;
    v = b;
    if (!v[5]) v[6] = 1'b1;
    wr = v[6] && (!v[3] || (!v[2] && !(v[1] && v[0])));
    if (wr) out_enable_n = 1'b1;
    bus = fbs_bus_s'(v);
    addr = a;
    drv = wr ? d : ~drv;
    @(posedge clk);
    #1;
  endtask

  // Sleep only from an idle bus, so nothing is left pending
  task automatic snooze_on();
    cyc(10'h17F, 20'h00000, 18'h00000);
    sleep_req = 1'b1;
    // Two quiet edges while the pin synchroniser catches up
    repeat (2) cyc(10'h17F, 20'h00000, 18'h00000);
  endtask

  // Wake, then only idle no-strobe cycles during recovery
  task automatic snooze_off();
    sleep_req = 1'b0;
    repeat (RECOV) cyc(10'h17F, 20'h00000, 18'h00000);
  endtask
endmodule

`default_nettype wire

// >>> tb/tb_flowthrough_burst_sram_interface.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %s expected %h seen %h", n, e, g); end end

module tb_flowthrough_burst_sram_interface;
  import fbs_pkg::*;
  // Bus words: msel, sel_hi, sel_lo, proc, ctrl, adv, gw, gate, bh, bl
  localparam logic [9:0] IDL = 10'h17F, PRD = 10'h12F, PGW = 10'h137, CGW = 10'h157;
  localparam logic [9:0] CON = 10'h16F, CBL = 10'h15A, CBH = 10'h159, CGH = 10'h15C;
  localparam logic [9:0] CNB = 10'h15B, PMS = 10'h33F, CHI = 10'h05F, PLO = 10'h1BF;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  fbs_bus_s bus;
  logic [19:0] addr;
  logic [17:0] dq_line, dq_out;
  logic dq_oe, oe_n, sleep_req, order_n, asleep;

  always #20 clk = ~clk;

  fbs_sram_port uut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .addr(addr),
    .dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe), .out_enable_n(oe_n),
    .sleep_req(sleep_req), .burst_order_sel_n(order_n), .asleep(asleep));
  fbs_ctl_model ctl (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .dq_line(dq_line),
    .bus(bus), .addr(addr), .out_enable_n(oe_n), .sleep_req(sleep_req),
    .burst_order_sel_n(order_n));

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Processor-strobe read with output enable low
  task automatic rd(input logic [19:0] a);
    ctl.out_enable_n = 1'b0;
    ctl.cyc(PRD, a, 18'h00000);
  endtask

  task automatic t_basic();
    `CHK("asleep", 1'b0, asleep)
    ctl.cyc(CGW, 20'h00010, 18'h2A5A5);
    `CHK("oe_wr", 1'b0, dq_oe)
    ctl.out_enable_n = 1'b0;
    ctl.cyc(PGW, 20'h00010, 18'h15A5A);
    `CHK("p_rd", 18'h2A5A5, dq_out)
    `CHK("oe_rd", 1'b1, dq_oe)
    #5 ctl.out_enable_n = 1'b1;
    #1 `CHK("oe_off", 1'b0, dq_oe)
    rd(20'h00010);
    `CHK("rd_back", 18'h2A5A5, dq_out)
  endtask

  task automatic t_bytes();
    ctl.cyc(CGW, 20'h00020, 18'h3FFFF);
    rd(20'h00020);
    `CHK("gw_all", 18'h3FFFF, dq_out)
    ctl.cyc(CBL, 20'h00020, 18'h00000);
    rd(20'h00020);
    `CHK("lane0", 18'h3FE00, dq_out)
    ctl.cyc(CBH, 20'h00020, 18'h00000);
    ctl.cyc(CGH, 20'h00020, 18'h3FFFF);
    rd(20'h00020);
    `CHK("gate_hi", 18'h00000, dq_out)
    ctl.out_enable_n = 1'b1;
    ctl.cyc(CNB, 20'h00020, 18'h3FFFF);
    rd(20'h00020);
    `CHK("no_byte", 18'h00000, dq_out)
  endtask

  // Four words at one base, then a burst from start s; adv low on the start edge
  task automatic t_burst(input logic ord, input logic [1:0] s);
    logic [1:0] lo;
    ctl.burst_order_sel_n = ord;
    for (int i = 0; i < 4; i++) begin
      ctl.cyc(CGW, {18'h2D2C1, i[1:0]}, {16'hC3A5, i[1:0]});
    end
    rd({18'h2D2C1, s});
    for (int k = 0; k < 4; k++) begin
      lo = ord ? (s ^ k[1:0]) : (s + k[1:0]);
      if (ord) `CHK("ilv", {16'hC3A5, lo}, dq_out)
      else `CHK("lin", {16'hC3A5, lo}, dq_out)
      ctl.cyc(CON, 20'h00000, 18'h00000);
    end
  endtask

  task automatic t_desel();
    rd(20'h00010);
    ctl.cyc(PMS, 20'h00010, 18'h00000);
    `CHK("msel", 1'b1, dq_oe)
    `CHK("msel_q", 18'h2A5A5, dq_out)
    ctl.cyc(CHI, 20'h00010, 18'h00000);
    `CHK("sel_hi", 1'b0, dq_oe)
    ctl.cyc(PLO, 20'h00010, 18'h00000);
    `CHK("sel_lo", 1'b0, dq_oe)
  endtask

  task automatic t_sleep();
    rd(20'h00010);
    ctl.snooze_on();
    #1 `CHK("zz_oe", 1'b0, dq_oe)
    repeat (3) ctl.cyc(CGW, 20'h00010, 18'h11111);
    `CHK("zz_on", 1'b1, asleep)
    ctl.snooze_off();
    ctl.cyc(IDL, 20'h00000, 18'h00000);
    `CHK("zz_off", 1'b0, asleep)
    rd(20'h00010);
    `CHK("kept", 18'h2A5A5, dq_out)
  endtask

  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Whole run needs well under a hundred edges
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      results();
    end
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 sys_rst = 1'b0;
    ctl.cyc(IDL, 20'h00000, 18'h00000);
    t_basic();
    t_bytes();
    t_burst(1'b1, 2'b01);
    t_burst(1'b0, 2'b10);
    t_desel();
    t_sleep();
    results();
  end
endmodule

`default_nettype wire
